// *** imsir_checker.sv ***
`timescale 1ns/1ps
module imsir_checker
  import imsir_pkg::*;
#(
  parameter logic [20:0] ACC_BOOT_CYC   = 21'd50000,
  parameter logic [20:0] GYR_SETTLE_CYC = 21'd1500000,
  parameter logic [20:0] GYR_DRDY_CYC   = 21'd14000
) (
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire imsir_req_t req,
  input wire logic [7:0] rdata,
  input wire logic       rvalid,
  input wire logic       accel_sample_valid,
  input wire logic       gyro_z_store,
  input wire logic       accel_busy,
  input wire logic       gyro_busy,
  input wire logic       irq_pin_a,
  input wire logic       irq_pin_b,
  input wire logic       irq_pin_c
);
  logic [20:0] since_store;
  logic [20:0] busy_run;
  logic [20:0] gbusy_run;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // saturating, so a long idle gap cannot wrap back into range
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) since_store <= '0;
    else if (gyro_z_store) since_store <= '0;
    else if (since_store != '1) since_store <= since_store + 21'd1;
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) busy_run <= '0;
    else if (accel_busy) busy_run <= busy_run + 21'd1;
    else busy_run <= '0;
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) gbusy_run <= '0;
    else if (gyro_busy) gbusy_run <= gbusy_run + 21'd1;
    else gbusy_run <= '0;
  end
  sequence s_rd;
    req.rd && (req.sel_accel ^ req.sel_gyro);
  endsequence
  sequence s_acc_rst;
    req.wr && req.sel_accel && !req.sel_gyro && req.addr == 8'h7e && req.wdata == 8'hb6 && !accel_busy;
  endsequence
  sequence s_gyr_rst;
    req.wr && req.sel_gyro && !req.sel_accel && req.addr == 8'h14 && req.wdata == 8'hb6 && !gyro_busy;
  endsequence
  a_read_answer: assert property (s_rd |=> rvalid)
    else $error("read got no answer");
  a_answer_cause: assert property (!(req.rd && (req.sel_accel ^ req.sel_gyro)) |=> !rvalid)
    else $error("answer without read");
  a_id_value: assert property (s_rd ##0 (req.sel_accel && req.addr == 8'h00 && !accel_busy) |=> rdata == 8'h5a)
    else $error("identity byte wrong");
  a_acc_reset_busy: assert property (s_acc_rst |=> accel_busy [*8])
    else $error("accel reset did not start");
  a_gyr_reset_busy: assert property (s_gyr_rst |=> gyro_busy [*8])
    else $error("gyro reset did not start");
  a_acc_boot_bound: assert property (accel_busy |-> busy_run <= ACC_BOOT_CYC + 21'd1)
    else $error("accel boot too long");
  a_gyr_settle_bound: assert property (gyro_busy |-> gbusy_run <= GYR_SETTLE_CYC + 21'd1)
    else $error("gyro settle too long");
  a_gyr_pulse_len: assert property (irq_pin_c |-> since_store <= GYR_DRDY_CYC + 21'd2)
    else $error("gyro ready not cleared");
  a_gyr_pulse_hold: assert property ($rose(irq_pin_c) |-> irq_pin_c [*8])
    else $error("gyro ready too short");
  a_gyr_pin_cause: assert property ($rose(irq_pin_c) |-> $past(gyro_z_store, 2))
    else $error("gyro pin without store");
  a_acc_pin_cause: assert property ($rose(irq_pin_a) || $rose(irq_pin_b) |-> $past(accel_sample_valid, 2))
    else $error("accel pin without sample");
endmodule
bind imsir_top imsir_checker #(
  .ACC_BOOT_CYC(ACC_BOOT_CYC), .GYR_SETTLE_CYC(GYR_SETTLE_CYC), .GYR_DRDY_CYC(GYR_DRDY_CYC)
) chk_u (
  .core_clk(core_clk), .nrst(nrst), .req(req), .rdata(rdata), .rvalid(rvalid),
  .accel_sample_valid(accel_sample_valid), .gyro_z_store(gyro_z_store), .accel_busy(accel_busy),
  .gyro_busy(gyro_busy), .irq_pin_a(irq_pin_a), .irq_pin_b(irq_pin_b), .irq_pin_c(irq_pin_c)
);

// *** imsir_defines.svh ***
`ifndef IMSIR_DEFINES_SVH
`define IMSIR_DEFINES_SVH

// clock and timing
`define IMSIR_CLK_MHZ        50
`define IMSIR_ACC_BOOT_US    1000
`define IMSIR_GYR_SETTLE_US  30000
`define IMSIR_GYR_DRDY_US    280
`define IMSIR_ACC_BOOT_CYC   (`IMSIR_ACC_BOOT_US * `IMSIR_CLK_MHZ)
`define IMSIR_GYR_SETTLE_CYC (`IMSIR_GYR_SETTLE_US * `IMSIR_CLK_MHZ)
`define IMSIR_GYR_DRDY_CYC   (`IMSIR_GYR_DRDY_US * `IMSIR_CLK_MHZ)
`define IMSIR_BIST_CYC       8'h40

// accelerometer map
`define IMSIR_A_CHIP_ID      8'h00
`define IMSIR_A_X_LSB        8'h12
`define IMSIR_A_X_MSB        8'h13
`define IMSIR_A_Y_LSB        8'h14
`define IMSIR_A_Y_MSB        8'h15
`define IMSIR_A_Z_LSB        8'h16
`define IMSIR_A_Z_MSB        8'h17
`define IMSIR_A_IRQ_STAT     8'h1d
`define IMSIR_A_CONFIG       8'h40
`define IMSIR_A_RANGE        8'h41
`define IMSIR_A_IRQ_MAP      8'h58
`define IMSIR_A_SELFTEST     8'h6d
`define IMSIR_A_PWR_CTRL     8'h7d
`define IMSIR_A_SOFTRESET    8'h7e

// gyroscope map
`define IMSIR_G_Z_LSB        8'h06
`define IMSIR_G_Z_MSB        8'h07
`define IMSIR_G_LPM1         8'h11
`define IMSIR_G_SOFTRESET    8'h14
`define IMSIR_G_INT_CTRL     8'h15
`define IMSIR_G_IRQ_MAP      8'h18
`define IMSIR_G_SELFTEST     8'h3c

// reset values and codes
`define IMSIR_A_CONFIG_RST   8'ha8
`define IMSIR_A_RANGE_RST    8'h01
`define IMSIR_SOFTRESET_CMD  8'hb6
`define IMSIR_A_PWR_NORMAL   8'h04
`define IMSIR_A_CHIP_ID_VAL  8'h5a // arbitrary identity value
`define IMSIR_A_ST_OFFSET    16'h1000

// field positions
`define IMSIR_A_ST_EN_BIT    0
`define IMSIR_A_ST_POS_BIT   2
`define IMSIR_A_DRDY_BIT     7
`define IMSIR_A_MAP_PA_BIT   2
`define IMSIR_A_MAP_PB_BIT   6
`define IMSIR_G_TRIG_BIT     0
`define IMSIR_G_RDY_BIT      1
`define IMSIR_G_FAIL_BIT     2
`define IMSIR_G_BG_BIT       4
`define IMSIR_G_DRDY_EN_BIT  7
`define IMSIR_G_MAP_PC_BIT   0
`define IMSIR_G_MAP_PD_BIT   2

`endif

// *** imsir_host.sv ***
`timescale 1ns/1ps
module imsir_host
  import imsir_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       accel_busy,
  input  wire logic       gyro_busy,
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid,
  output imsir_req_t      req
);
  logic hung;
  initial begin
    req = '0;
    hung = 1'b0;
  end
  task automatic idle_wait(input logic acc);
    int n;
    n = 0;
    #1;
    while ((acc ? accel_busy : gyro_busy) !== 1'b0 && n < 200) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n == 200) hung = 1'b1;
  endtask
  task automatic wr(input logic acc, input logic [7:0] a, input logic [7:0] d);
    idle_wait(acc);
    @(posedge core_clk);
    req <= {acc, !acc, a, d, 2'b10};
    @(posedge core_clk);
    req <= '0;
  endtask
  task automatic rd(input logic acc, input logic [7:0] a, output logic [7:0] d);
    idle_wait(acc);
    @(posedge core_clk);
    req <= {acc, !acc, a, 8'h00, 2'b01};
    @(posedge core_clk);
    req <= '0;
    #1;
    d = (rvalid === 1'b1) ? rdata : 8'hxx;
  endtask
  task automatic rmw(input logic acc, input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
    logic [7:0] d;
    rd(acc, a, d);
    wr(acc, a, (d & ~m) | (v & m));
  endtask
  task automatic st_prep;
    wr(1'b1, 8'h41, 8'h03);
    wr(1'b1, 8'h40, 8'ha7);
    repeat (4) @(posedge core_clk);
  endtask
  // polarity code then settle; waits short, no analog here
  task automatic st_mode(input logic [7:0] code);
    wr(1'b1, 8'h6d, code);
    repeat (4) @(posedge core_clk);
  endtask
  task automatic part_reset(input logic acc);
    wr(acc, acc ? 8'h7e : 8'h14, 8'hb6);
    #1;
  endtask
endmodule

// *** imsir_pkg.sv ***
package imsir_pkg;

  typedef struct packed {
    logic       sel_accel;
    logic       sel_gyro;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } imsir_req_t;

  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } imsir_axes_t;

  typedef enum logic {
    BIST_IDLE = 1'b0,
    BIST_RUN  = 1'b1
  } imsir_bist_t;

endpackage

// *** imsir_top.sv ***
`timescale 1ns/1ps
`include "imsir_defines.svh"
module imsir_top
  import imsir_pkg::*;
#(
  parameter logic [20:0] ACC_BOOT_CYC   = 21'(`IMSIR_ACC_BOOT_CYC),
  parameter logic [20:0] GYR_SETTLE_CYC = 21'(`IMSIR_GYR_SETTLE_CYC),
  parameter logic [20:0] GYR_DRDY_CYC   = 21'(`IMSIR_GYR_DRDY_CYC)
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire imsir_req_t  req,
  output logic [7:0]       rdata,
  output logic             rvalid,
  input  wire logic        accel_sample_valid,
  input  wire imsir_axes_t accel_sample,
  input  wire logic        gyro_z_store,
  input  wire logic [15:0] gyro_z_sample,
  input  wire logic        gyro_sense_ok,
  output logic             accel_busy,
  output logic             gyro_busy,
  output logic             irq_pin_a,
  output logic             irq_pin_b,
  output logic             irq_pin_c,
  output logic             irq_pin_d
);

  // accel config and data
  logic [7:0]  accel_config;
  logic [7:0]  accel_range_select;
  logic [7:0]  accel_selftest_control;
  logic [7:0]  accel_irq_map;
  logic [7:0]  accel_pwr;
  imsir_axes_t accel_data;
  logic        accel_drdy;
  logic [20:0] accel_boot_cnt;
  logic        accel_sr_pend;
  // gyro config and state
  logic [7:0]  gyro_int_ctrl;
  logic [7:0]  gyro_irq_map;
  logic [7:0]  gyro_lpm1;
  logic [15:0] gyro_z;
  logic        gyro_rdy;
  logic        gyro_fail;
  logic        gyro_bg_ok;
  imsir_bist_t bist_state;
  logic [7:0]  bist_cnt;
  logic [20:0] gyro_settle_cnt;
  logic        gyro_sr_pend;
  logic [20:0] gyro_drdy_cnt;
  logic        gyro_drdy;
  logic        a_wr;
  logic        g_wr;
  logic        a_sr_cmd;
  logic        g_sr_cmd;
  logic        a_restore;
  logic        g_restore;
  logic [15:0] st_offset;
  // writes while a part boots are dropped
  assign a_wr      = req.wr && req.sel_accel && !accel_busy;
  assign g_wr      = req.wr && req.sel_gyro && !gyro_busy;
  assign a_sr_cmd  = a_wr && req.addr == `IMSIR_A_SOFTRESET && req.wdata == `IMSIR_SOFTRESET_CMD;
  assign g_sr_cmd  = g_wr && req.addr == `IMSIR_G_SOFTRESET && req.wdata == `IMSIR_SOFTRESET_CMD;
  // defaults land when the delay ends
  assign a_restore = accel_sr_pend && accel_boot_cnt == 21'h000001;
  assign g_restore = gyro_sr_pend && gyro_settle_cnt == 21'h000001;
  function automatic logic hit(input logic w, input logic [7:0] a, input logic [7:0] off);
    hit = w && (a == off);
  endfunction
  // polarity bit picks sign of injected offset
  assign st_offset = accel_selftest_control[`IMSIR_A_ST_POS_BIT] ? `IMSIR_A_ST_OFFSET : 16'h0000 - `IMSIR_A_ST_OFFSET;
  // boot window after soft reset only
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      accel_boot_cnt <= 21'h000000;
      accel_sr_pend  <= 1'b0;
      accel_busy     <= 1'b0;
    end else begin
      if (a_sr_cmd) begin
        accel_boot_cnt <= ACC_BOOT_CYC;
        accel_sr_pend  <= 1'b1;
      end else if (accel_boot_cnt != 21'h000000) begin
        accel_boot_cnt <= accel_boot_cnt - 21'h000001;
      end
      if (a_restore) begin
        accel_sr_pend <= 1'b0;
      end
      accel_busy <= a_sr_cmd || accel_boot_cnt > 21'h000001;
    end
  end
  // accel configuration registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      accel_config           <= `IMSIR_A_CONFIG_RST;
      accel_range_select     <= `IMSIR_A_RANGE_RST;
      accel_selftest_control <= 8'h00;
      accel_irq_map          <= 8'h00;
      accel_pwr              <= 8'h00;
    end else if (a_restore) begin
      // back to suspend after soft reset
      accel_config           <= `IMSIR_A_CONFIG_RST;
      accel_range_select     <= `IMSIR_A_RANGE_RST;
      accel_selftest_control <= 8'h00;
      accel_irq_map          <= 8'h00;
      accel_pwr              <= 8'h00;
    end else begin
      // byte-wide writes into the accel map
      if (hit(a_wr, req.addr, `IMSIR_A_CONFIG)) accel_config <= req.wdata;
      if (hit(a_wr, req.addr, `IMSIR_A_RANGE)) accel_range_select <= req.wdata;
      if (hit(a_wr, req.addr, `IMSIR_A_SELFTEST)) accel_selftest_control <= req.wdata;
      if (hit(a_wr, req.addr, `IMSIR_A_IRQ_MAP)) accel_irq_map <= req.wdata;
      if (hit(a_wr, req.addr, `IMSIR_A_PWR_CTRL)) accel_pwr <= req.wdata;
    end
  end
  // accel data and new-data flag
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      accel_data <= '0;
      accel_drdy <= 1'b0;
    end else if (a_restore) begin
      accel_data <= '0;
      accel_drdy <= 1'b0;
    end else if (accel_sample_valid && accel_pwr == `IMSIR_A_PWR_NORMAL) begin
      if (accel_selftest_control[`IMSIR_A_ST_EN_BIT]) begin
        accel_data.x <= accel_sample.x + st_offset;
        accel_data.y <= accel_sample.y + st_offset;
        accel_data.z <= accel_sample.z + st_offset;
      end else begin
        accel_data <= accel_sample;
      end
      // set wins over the read clear
      accel_drdy <= 1'b1;
    end else if (req.rd && req.sel_accel && !accel_busy && req.addr == `IMSIR_A_IRQ_STAT) begin
      accel_drdy <= 1'b0;
    end
  end
  // settle window after soft reset or mode change
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gyro_settle_cnt <= 21'h000000;
      gyro_sr_pend    <= 1'b0;
      gyro_busy       <= 1'b0;
    end else begin
      if (g_sr_cmd || hit(g_wr, req.addr, `IMSIR_G_LPM1)) begin
        gyro_settle_cnt <= GYR_SETTLE_CYC;
      end else if (gyro_settle_cnt != 21'h000000) begin
        gyro_settle_cnt <= gyro_settle_cnt - 21'h000001;
      end
      if (g_sr_cmd) begin
        gyro_sr_pend <= 1'b1;
      end else if (g_restore) begin
        gyro_sr_pend <= 1'b0;
      end
      gyro_busy <= g_sr_cmd || hit(g_wr, req.addr, `IMSIR_G_LPM1) || gyro_settle_cnt > 21'h000001;
    end
  end
  // gyro configuration registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gyro_int_ctrl <= 8'h00;
      gyro_irq_map  <= 8'h00;
      gyro_lpm1     <= 8'h00;
    end else if (g_restore) begin
      gyro_int_ctrl <= 8'h00;
      gyro_irq_map  <= 8'h00;
      gyro_lpm1     <= 8'h00;
    end else begin
      // enable bit only by host write
      if (hit(g_wr, req.addr, `IMSIR_G_INT_CTRL)) gyro_int_ctrl <= req.wdata;
      if (hit(g_wr, req.addr, `IMSIR_G_IRQ_MAP)) gyro_irq_map <= req.wdata;
      if (hit(g_wr, req.addr, `IMSIR_G_LPM1)) gyro_lpm1 <= req.wdata;
    end
  end

  // built-in self-test sequencer
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bist_state <= BIST_IDLE;
      bist_cnt   <= 8'h00;
      gyro_rdy   <= 1'b0;
      gyro_fail  <= 1'b0;
    end else if (g_restore) begin
      bist_state <= BIST_IDLE;
      bist_cnt   <= 8'h00;
      gyro_rdy   <= 1'b0;
      gyro_fail  <= 1'b0;
    end else begin
      unique case (bist_state)
        BIST_IDLE: begin
          // one-shot, results held till next trigger or soft reset
          if (hit(g_wr, req.addr, `IMSIR_G_SELFTEST) && req.wdata[`IMSIR_G_TRIG_BIT]) begin
            bist_state <= BIST_RUN;
            bist_cnt   <= `IMSIR_BIST_CYC;
            gyro_rdy   <= 1'b0;
            gyro_fail  <= 1'b0;
          end
        end
        BIST_RUN: begin
          bist_cnt <= bist_cnt - 8'h01;
          if (bist_cnt == 8'h01) begin
            bist_state <= BIST_IDLE;
            gyro_rdy   <= 1'b1;
            gyro_fail  <= !gyro_sense_ok;
          end
        end
      endcase
    end
  end

  // gyro data, background check, data-ready pulse
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gyro_z        <= 16'h0000;
      gyro_bg_ok    <= 1'b0;
      gyro_drdy     <= 1'b0;
      gyro_drdy_cnt <= 21'h000000;
    end else begin
      gyro_bg_ok <= gyro_sense_ok;
      if (gyro_z_store) begin
        gyro_z <= gyro_z_sample;
      end
      // fixed-width pulse after each z store while gyro_int_ctrl is 8'h80
      if (gyro_z_store && gyro_int_ctrl == 8'h80 && !g_restore) begin
        gyro_drdy     <= 1'b1;
        gyro_drdy_cnt <= GYR_DRDY_CYC;
      end else if (gyro_drdy_cnt > 21'h000001) begin
        gyro_drdy_cnt <= gyro_drdy_cnt - 21'h000001;
      end else begin
        gyro_drdy     <= 1'b0;
        gyro_drdy_cnt <= 21'h000000;
      end
    end
  end

  // interrupt pins, registered
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq_pin_a <= 1'b0;
      irq_pin_b <= 1'b0;
      irq_pin_c <= 1'b0;
      irq_pin_d <= 1'b0;
    end else begin
      // accel map picks pins a and b
      irq_pin_a <= accel_drdy && accel_irq_map[`IMSIR_A_MAP_PA_BIT];
      irq_pin_b <= accel_drdy && accel_irq_map[`IMSIR_A_MAP_PB_BIT];
      // gyro map picks pins c and d
      irq_pin_c <= gyro_drdy && gyro_irq_map[`IMSIR_G_MAP_PC_BIT];
      irq_pin_d <= gyro_drdy && gyro_irq_map[`IMSIR_G_MAP_PD_BIT];
    end
  end

  // read mux; busy parts and unmapped addresses read zero
  function automatic logic [7:0] accel_read(input logic [7:0] a);
    unique case (a)
      `IMSIR_A_CHIP_ID:   accel_read = `IMSIR_A_CHIP_ID_VAL;
      `IMSIR_A_X_LSB:     accel_read = accel_data.x[7:0];
      `IMSIR_A_X_MSB:     accel_read = accel_data.x[15:8];
      `IMSIR_A_Y_LSB:     accel_read = accel_data.y[7:0];
      `IMSIR_A_Y_MSB:     accel_read = accel_data.y[15:8];
      `IMSIR_A_Z_LSB:     accel_read = accel_data.z[7:0];
      `IMSIR_A_Z_MSB:     accel_read = accel_data.z[15:8];
      `IMSIR_A_IRQ_STAT:  accel_read = {accel_drdy, 7'h00};
      `IMSIR_A_CONFIG:    accel_read = accel_config;
      `IMSIR_A_RANGE:     accel_read = accel_range_select;
      `IMSIR_A_IRQ_MAP:   accel_read = accel_irq_map;
      `IMSIR_A_SELFTEST:  accel_read = accel_selftest_control;
      `IMSIR_A_PWR_CTRL:  accel_read = accel_pwr;
      default:            accel_read = 8'h00;
    endcase
  endfunction
  function automatic logic [7:0] gyro_read(input logic [7:0] a);
    unique case (a)
      `IMSIR_G_Z_LSB:     gyro_read = gyro_z[7:0];
      `IMSIR_G_Z_MSB:     gyro_read = gyro_z[15:8];
      `IMSIR_G_LPM1:      gyro_read = gyro_lpm1;
      `IMSIR_G_INT_CTRL:  gyro_read = gyro_int_ctrl;
      `IMSIR_G_IRQ_MAP:   gyro_read = gyro_irq_map;
      // status bits; trigger reads back zero
      `IMSIR_G_SELFTEST:  gyro_read = {3'h0, gyro_bg_ok, 1'b0, gyro_fail, gyro_rdy, 1'b0};
      default:            gyro_read = 8'h00;
    endcase
  endfunction

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata  <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd && (req.sel_accel ^ req.sel_gyro);
      if (req.rd && req.sel_accel && !req.sel_gyro && !accel_busy) begin
        rdata <= accel_read(req.addr);
      end else if (req.rd && req.sel_gyro && !req.sel_accel && !gyro_busy) begin
        rdata <= gyro_read(req.addr);
      end else begin
        rdata <= 8'h00;
      end
    end
  end

endmodule

// *** test_imu_selftest_irq_reset.sv ***
`timescale 1ns/1ps
module test_imu_selftest_irq_reset
  import imsir_pkg::*;
;
  logic        core_clk, nrst, acc_valid, gz_store, sense_ok;
  logic        rvalid, abusy, gbusy, pa, pb, pc, pd;
  logic [7:0]  rdata, d, dh;
  logic [15:0] gz_smp, v, diff;
  logic [15:0] resp [2];
  imsir_axes_t acc_smp;
  imsir_req_t  req;
  int          mismatches, checked, i, j, n;
  logic [7:0]  mp [3] = '{8'h04, 8'h40, 8'h44};
  logic [7:0]  gm [3] = '{8'h01, 8'h04, 8'h05};
  logic [7:0]  stc [3] = '{8'h0d, 8'h09, 8'h00};
  logic [15:0] off [3] = '{16'h1000, 16'hf000, 16'h0000};

  imsir_top #(.ACC_BOOT_CYC(21'd20), .GYR_SETTLE_CYC(21'd30), .GYR_DRDY_CYC(21'd10)) dut_u (
    .core_clk(core_clk), .nrst(nrst), .req(req), .rdata(rdata), .rvalid(rvalid),
    .accel_sample_valid(acc_valid), .accel_sample(acc_smp), .gyro_z_store(gz_store),
    .gyro_z_sample(gz_smp), .gyro_sense_ok(sense_ok), .accel_busy(abusy), .gyro_busy(gbusy),
    .irq_pin_a(pa), .irq_pin_b(pb), .irq_pin_c(pc), .irq_pin_d(pd));
  imsir_host host_u (.core_clk(core_clk), .accel_busy(abusy), .gyro_busy(gbusy),
    .rdata(rdata), .rvalid(rvalid), .req(req));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic acc, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] r;
    host_u.rd(acc, a, r);
    chk(r, exp);
  endtask
  task automatic fire(input logic acc);
    @(posedge core_clk);
    if (acc) acc_valid <= 1'b1;
    else gz_store <= 1'b1;
    @(posedge core_clk);
    acc_valid <= 1'b0;
    gz_store <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // cuts a hang short
  initial begin
    #2000000;
    mismatches++;
    conclude();
  end
  initial begin
    nrst = 1'b0; acc_valid = 1'b0; gz_store = 1'b0; sense_ok = 1'b1;
    mismatches = 0; checked = 0; gz_smp = 16'h0abc;
    acc_smp = {16'h0123, 16'h0456, 16'h0789};
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    rchk(1'b1, 8'h40, 8'ha8);
    rchk(1'b1, 8'h41, 8'h01);
    rchk(1'b1, 8'h00, 8'h5a);
    rchk(1'b1, 8'h30, 8'h00);
    rchk(1'b0, 8'h40, 8'h00);
    rchk(1'b0, 8'h3c, 8'h10);
    $display("test defaults done");
    fire(1'b1);
    rchk(1'b1, 8'h1d, 8'h00);
    host_u.wr(1'b1, 8'h7d, 8'h04);
    for (i = 0; i < 3; i++) begin
      host_u.rmw(1'b1, 8'h58, 8'h44, mp[i]);
      fire(1'b1);
      chk({6'h0, pa, pb}, {6'h0, mp[i][2], mp[i][6]});
      rchk(1'b1, 8'h1d, 8'h80);
      rchk(1'b1, 8'h1d, 8'h00);
    end
    host_u.st_prep();
    for (i = 0; i < 3; i++) begin
      host_u.st_mode(stc[i]);
      fire(1'b1);
      for (j = 0; j < 6; j++) begin
        v = acc_smp[47 - 16 * (j / 2) -: 16] + off[i];
        rchk(1'b1, 8'h12 + 8'(j), j % 2 ? v[15:8] : v[7:0]);
      end
      if (i < 2) begin
        host_u.rd(1'b1, 8'h16, d);
        host_u.rd(1'b1, 8'h17, dh);
        resp[i] = {dh, d};
      end
    end
    // positive minus negative z response, wraps in 16 bits
    diff = resp[0] - resp[1];
    chk(diff[15:8], 8'h20);
    chk(diff[7:0], 8'h00);
    $display("test accel done");
    fire(1'b0);
    chk({6'h0, pc, pd}, 8'h00);
    host_u.wr(1'b0, 8'h15, 8'h80);
    for (i = 0; i < 3; i++) begin
      host_u.rmw(1'b0, 8'h18, 8'h05, gm[i]);
      fire(1'b0);
      chk({6'h0, pc, pd}, {6'h0, gm[i][0], gm[i][2]});
      repeat (12) @(posedge core_clk);
      #1;
      chk({6'h0, pc, pd}, 8'h00);
    end
    rchk(1'b0, 8'h06, 8'hbc);
    rchk(1'b0, 8'h07, 8'h0a);
    $display("test gyro irq done");
    for (i = 0; i < 2; i++) begin
      @(posedge core_clk);
      sense_ok <= (i == 0);
      host_u.wr(1'b0, 8'h3c, 8'h01);
      d = 8'h00;
      n = 0;
      while (d[1] !== 1'b1 && n < 100) begin
        host_u.rd(1'b0, 8'h3c, d);
        n++;
      end
      chk(d, i ? 8'h06 : 8'h12);
      rchk(1'b0, 8'h3c, i ? 8'h06 : 8'h12);
    end
    $display("test bist done");
    host_u.part_reset(1'b1);
    chk({6'h0, abusy, gbusy}, 8'h02);
    rchk(1'b1, 8'h40, 8'ha8);
    rchk(1'b1, 8'h58, 8'h00);
    rchk(1'b1, 8'h7d, 8'h00);
    rchk(1'b0, 8'h15, 8'h80);
    host_u.part_reset(1'b0);
    rchk(1'b0, 8'h15, 8'h00);
    rchk(1'b0, 8'h18, 8'h00);
    host_u.wr(1'b0, 8'h11, 8'h80);
    #1;
    chk({7'h0, gbusy}, 8'h01);
    rchk(1'b0, 8'h11, 8'h80);
    chk({7'h0, host_u.hung}, 8'h00);
    $display("test soft reset done");
    conclude();
  end
endmodule
